// ==== adc_result_autoscan_regs_bench.sv ====
// self-checking bench of the converter result and auto-scan block
`timescale 1ns/1ps
`include "adcrs_map.svh"
module adc_result_autoscan_regs_bench import adcrs_pkg::*;;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [3:0] dly = 4'h0;
    logic [9:0] base = 10'h000;
    logic [7:0] rd_data;
    logic done;
    logic [9:0] cdata;
    logic start;
    logic [4:0] chan;
    logic cont;
    logic [7:0] asel;
    logic req;
    logic irq;
    logic busy;
    logic [4:0] chs [0:7];
    int starts = 0;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    always #12.5 ref_clk_i = ~ref_clk_i;
    adcrs_top #(.NPIN(8)) DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr_en), .rd_en_i(rd_en),
        .rd_data_o(rd_data), .conv_done_i(done), .conv_data_i(cdata),
        .conv_start_o(start), .conv_channel_o(chan), .continuous_o(cont),
        .analog_sel_o(asel), .conv_req_o(req), .irq_o(irq));
    adcrs_core_model core (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .start_i(start), .chan_i(chan), .dly_i(dly), .base_i(base),
        .done_o(done), .data_o(cdata), .busy_o(busy));
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // records the channel of every start and cuts a hang short
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (start === 1'b1) begin
            chs[starts[2:0]] <= chan;
            starts <= starts + 1;
        end
        if (cycles == 20000) begin
            bad_count++;
            final_report();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk_i);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk_i);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        check({8'h00, v}, {8'h00, e});
    endtask
    task automatic settle();
        int q;
        q = 0;
        for (int i = 0; i < 400 && q < 3; i++) begin
            @(posedge ref_clk_i);
            #1;
            q = (busy || done || start) ? 0 : q + 1;
        end
        if (q < 3) bad_count++;
    endtask
    function automatic logic [15:0] fmt(input adcrs_mode_t m,
        input logic [9:0] v);
        case (m)
            MD_TRUNC: return {8'h00, v[9:2]};
            MD_RIGHT: return {6'h00, v};
            MD_LEFT: return {v, 6'h00};
            default: return {~v[9], v[8:0], 6'h00};
        endcase
    endfunction
    function automatic logic [9:0] val(input logic [4:0] c);
        return base + {1'b0, c, 4'h0};
    endfunction
    task automatic t_reset();
        logic [7:0] e;
        for (int a = 'h57; a <= 'h61; a++) begin
            e = (a == 'h57) ? 8'h1F : (a == 'h58) ? 8'h04 : 8'h00;
            rdc(a[15:0], e);
        end
        check({10'h000, cont, chan}, 16'h001F);
        check({8'h00, asel}, 16'h0000);
    endtask
    task automatic t_formats();
        logic [7:0] h;
        logic [7:0] l;
        adcrs_mode_t m;
        base = 10'h2C5;
        for (int i = 0; i < 4; i++) begin
            m = adcrs_mode_t'(i[1:0]);
            dly = 4'(i * 4);
            wr(`AR_OFS_CLK, {4'h0, m, 2'b00});
            wr(`AR_OFS_STAT, 8'h03);
            settle();
            check({8'h00, asel}, 16'h0008);
            rdc(`AR_OFS_STAT, 8'h83);
            rd(`AR_OFS_HIGH, h);
            rd(`AR_OFS_LOW0, l);
            check({h, l}, fmt(m, val(5'h03)));
            rdc(`AR_OFS_STAT, 8'h03);
        end
    endtask
    task automatic t_lock();
        logic [7:0] h;
        logic [7:0] l;
        logic [15:0] e;
        adcrs_mode_t m;
        dly = 4'h1;
        for (int i = 0; i < 2; i++) begin
            m = (i == 0) ? MD_TRUNC : MD_RIGHT;
            wr(`AR_OFS_CLK, {4'h0, m, 2'b00});
            wr(`AR_OFS_IST, 8'h03);
            base = 10'h155;
            wr(`AR_OFS_STAT, 8'h01);
            settle();
            rd(`AR_OFS_HIGH, h);
            base = 10'h2AA;
            wr(`AR_OFS_STAT, 8'h01);
            settle();
            rd(`AR_OFS_LOW0, l);
            e = (i == 0) ? fmt(MD_TRUNC, val(5'h01)) : fmt(m, 10'h165);
            check({8'h00, l}, {8'h00, e[7:0]});
            rdc(`AR_OFS_IST, (i == 0) ? 8'h01 : 8'h03);
            base = 10'h0F0;
            wr(`AR_OFS_STAT, 8'h01);
            settle();
            rd(`AR_OFS_HIGH, h);
            rd(`AR_OFS_LOW0, l);
            check({h, l}, fmt(m, val(5'h01)));
        end
        wr(`AR_OFS_LOW0, 8'hFF);
        wr(`AR_OFS_HIGH, 8'hFF);
        rdc(`AR_OFS_LOW0, l);
        rdc(`AR_OFS_HIGH, h);
    endtask
    task automatic t_scan();
        logic [15:0] f;
        int s0;
        wr(`AR_OFS_CLK, 8'h00);
        dly = 4'h2;
        for (int n = 0; n < 4; n++) begin
            base = 10'(10'h103 + n * 64);
            s0 = starts;
            wr(`AR_OFS_SCAN, {5'h00, n[1:0], 1'b1});
            rdc(`AR_OFS_SCAN, {5'h00, n[1:0], 1'b1});
            wr(`AR_OFS_STAT, 8'h00);
            settle();
            check(16'(starts - s0), 16'(n + 1));
            for (int k = 0; k <= n; k++) begin
                check({11'h000, chs[3'(s0 + k)]}, 16'(k));
                f = fmt(MD_TRUNC, val(k[4:0]));
                rdc(16'(`AR_OFS_LOW0 + k), f[7:0]);
            end
        end
        s0 = starts;
        wr(`AR_OFS_SCAN, 8'h00);
        wr(`AR_OFS_STAT, 8'h00);
        settle();
        check(16'(starts - s0), 16'h0001);
    endtask
    task automatic t_irq();
        logic [7:0] v;
        wr(`AR_OFS_CLK, 8'h04);
        wr(`AR_OFS_IST, 8'h03);
        wr(`AR_OFS_IMSK, 8'h01);
        wr(`AR_OFS_STAT, 8'h42);
        settle();
        check({14'h0000, req, irq}, 16'h0003);
        rdc(`AR_OFS_STAT, 8'h42);
        rd(`AR_OFS_HIGH, v);
        check({14'h0000, req, irq}, 16'h0001);
        rd(`AR_OFS_LOW0, v);
        wr(`AR_OFS_IST, 8'h01);
        @(posedge ref_clk_i);
        #1;
        check({15'h0000, irq}, 16'h0000);
        wr(`AR_OFS_IMSK, 8'h00);
        wr(`AR_OFS_STAT, 8'h42);
        settle();
        check({14'h0000, req, irq}, 16'h0002);
        rdc(`AR_OFS_IST, 8'h01);
        wr(`AR_OFS_STAT, 8'h5F);
        check({15'h0000, req}, 16'h0000);
        rdc(`AR_OFS_IMSK, 8'h00);
        wr(`AR_OFS_STAT, 8'h7F);
        rdc(`AR_OFS_STAT, 8'h7F);
        check({15'h0000, cont}, 16'h0001);
    endtask
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_formats();
        t_lock();
        t_scan();
        t_irq();
        final_report();
    end
endmodule

// ==== adcrs_core_model.sv ====
// behavioural analog conversion core that answers start pulses
`timescale 1ns/1ps
module adcrs_core_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [4:0] chan_i,
    input wire logic [3:0] dly_i,
    input wire logic [9:0] base_i,
    output logic done_o,
    output logic [9:0] data_o,
    output logic busy_o
);
    logic [3:0] cnt;
    logic [4:0] chan;
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= 4'h0;
            chan <= 5'h00;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            data_o <= 10'h000;
        end else begin
            done_o <= 1'b0;
            // data are only valid beside the done pulse
            if (done_o) begin
                data_o <= ~data_o;
            end
            if (start_i) begin
                busy_o <= 1'b1;
                cnt <= dly_i;
                chan <= chan_i;
            end else if (busy_o && cnt == 4'h0) begin
                busy_o <= 1'b0;
                done_o <= 1'b1;
                data_o <= base_i + {1'b0, chan, 4'h0};
            end else if (busy_o) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

// ==== adcrs_map.svh ====
// register offsets, field positions and reset values of the result block
`ifndef ADCRS_MAP_SVH
`define ADCRS_MAP_SVH
`define AR_OFS_STAT 16'h0057
`define AR_OFS_CLK 16'h0058
`define AR_OFS_HIGH 16'h0059
`define AR_OFS_LOW0 16'h005A
`define AR_OFS_LOW1 16'h005B
`define AR_OFS_LOW2 16'h005C
`define AR_OFS_LOW3 16'h005D
`define AR_OFS_SCAN 16'h005E
`define AR_OFS_IST 16'h0060
`define AR_OFS_IMSK 16'h0061
`define AR_DONE_BIT 7
`define AR_IEN_BIT 6
`define AR_CONT_BIT 5
`define AR_SEN_BIT 0
`define AR_CNT_LSB 1
`define AR_EV_DONE 0
`define AR_EV_LOST 1
`define AR_RST_CHAN 5'h1F
`define AR_OFF_CHAN 5'h1F
`define AR_RST_CFG 6'h01
`define AR_RST_RES 8'h00
`endif

// ==== adcrs_pkg.sv ====
// types shared by the converter result block
package adcrs_pkg;
    typedef enum logic [1:0] {
        MD_TRUNC = 2'b00,
        MD_RIGHT = 2'b01,
        MD_LEFT = 2'b10,
        MD_SIGNED = 2'b11
    } adcrs_mode_t;
    typedef enum logic [1:0] {
        LK_OPEN = 2'b01,
        LK_HELD = 2'b10
    } adcrs_lock_t;
endpackage

// ==== adcrs_top.sv ====
// result registers, justification and auto-scan control of the converter
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`include "adcrs_map.svh"
module adcrs_top
    import adcrs_pkg::*;
#(
    parameter int NPIN = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [7:0] rd_data_o,
    input wire logic conv_done_i,
    input wire logic [9:0] conv_data_i,
    output logic conv_start_o,
    output logic [4:0] conv_channel_o,
    output logic continuous_o,
    output logic [NPIN-1:0] analog_sel_o,
    output logic conv_req_o,
    output logic irq_o
);
    logic [7:0] res_high;
    logic [7:0] next_res_high;
    logic [7:0] res_low;
    logic [7:0] next_res_low;
    logic [7:0] scan_res [1:3];
    logic [7:0] next_scan_res [1:3];
    logic done_flag;
    logic next_done_flag;
    logic ien;
    logic next_ien;
    logic next_cont;
    logic [4:0] chan_sel;
    logic [4:0] next_chan_sel;
    logic [5:0] clk_cfg;
    logic [5:0] next_clk_cfg;
    logic [1:0] scan_cnt;
    logic [1:0] next_scan_cnt;
    logic scan_en;
    logic next_scan_en;
    logic [1:0] scan_idx;
    logic [1:0] next_scan_idx;
    adcrs_lock_t lock;
    adcrs_lock_t next_lock;
    logic [1:0] int_st;
    logic [1:0] next_int_st;
    logic [1:0] int_msk;
    logic [1:0] next_int_msk;
    logic [7:0] next_rd_data;
    logic next_start;
    logic [4:0] next_chan_out;
    logic [NPIN-1:0] next_sel;
    logic next_req;
    logic next_irq;
    adcrs_mode_t mode;
    logic wr_stat;
    logic wr_clk;
    logic wr_scan;
    logic wr_ist;
    logic wr_imsk;
    logic rd_high0;
    logic rd_low0;
    logic rd_low_any;
    logic take0;

    // justification field sits in the low two bits of the clock config
    assign mode = adcrs_mode_t'(clk_cfg[1:0]);
    assign wr_stat = wr_en_i && addr_i == `AR_OFS_STAT;
    assign wr_clk = wr_en_i && addr_i == `AR_OFS_CLK;
    assign wr_scan = wr_en_i && addr_i == `AR_OFS_SCAN;
    assign wr_ist = wr_en_i && addr_i == `AR_OFS_IST;
    assign wr_imsk = wr_en_i && addr_i == `AR_OFS_IMSK;
    assign rd_high0 = rd_en_i && addr_i == `AR_OFS_HIGH;
    assign rd_low0 = rd_en_i && addr_i == `AR_OFS_LOW0;
    assign rd_low_any = rd_en_i && addr_i >= `AR_OFS_LOW0
        && addr_i <= `AR_OFS_LOW3;
    // channel 0 of a scan, or any single conversion, lands in result zero
    assign take0 = !scan_en || scan_idx == 2'b00;
    for (genvar i = 1; i <= 3; i++) begin : g_scan
        always_comb begin
            next_scan_res[i] = scan_res[i];
            if (conv_done_i && scan_en && scan_idx == 2'(i)) begin
                next_scan_res[i] = conv_data_i[9:2];
            end
        end
        always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
                scan_res[i] <= `AR_RST_RES;
            end else begin
                scan_res[i] <= next_scan_res[i];
            end
        end
    end

    always_comb begin
        next_res_high = res_high;
        next_res_low = res_low;
        next_done_flag = done_flag;
        next_ien = ien;
        next_cont = continuous_o;
        next_chan_sel = chan_sel;
        next_clk_cfg = clk_cfg;
        next_scan_cnt = scan_cnt;
        next_scan_en = scan_en;
        next_scan_idx = scan_idx;
        next_lock = lock;
        next_int_st = int_st;
        next_int_msk = int_msk;
        next_req = conv_req_o;
        next_start = 1'b0;
        if (wr_stat) begin
            next_ien = wr_data_i[`AR_IEN_BIT];
            next_cont = wr_data_i[`AR_CONT_BIT];
            next_chan_sel = wr_data_i[4:0];
            next_done_flag = 1'b0;
            next_req = 1'b0;
            next_scan_idx = 2'b00;
            next_start = wr_data_i[4:0] != `AR_OFF_CHAN;
        end
        if (wr_clk) begin
            next_clk_cfg = wr_data_i[7:2];
            next_done_flag = 1'b0;
            next_lock = LK_OPEN;
        end
        if (wr_scan) begin
            next_scan_en = wr_data_i[`AR_SEN_BIT];
            next_scan_cnt = wr_data_i[`AR_CNT_LSB+:2];
            next_scan_idx = 2'b00;
        end
        if (wr_ist) begin
            next_int_st = int_st & ~wr_data_i[1:0];
        end
        if (wr_imsk) begin
            next_int_msk = wr_data_i[1:0];
        end
        if (rd_low_any && !ien) begin
            next_done_flag = 1'b0;
        end
        if (rd_low0 || rd_high0) begin
            next_req = 1'b0;
        end
        if (rd_high0 && mode != MD_TRUNC) begin
            next_lock = LK_HELD;
        end
        if (rd_low0) begin
            next_lock = LK_OPEN;
        end
        // completion comes last so that a set beats a clear
        if (conv_done_i) begin
            next_int_st[`AR_EV_DONE] = 1'b1;
            if (ien) begin
                next_req = 1'b1;
            end else begin
                next_done_flag = 1'b1;
            end
            if (scan_en) begin
                if (scan_idx == scan_cnt) begin
                    next_scan_idx = 2'b00;
                end else begin
                    next_scan_idx = scan_idx + 2'b01;
                    next_start = 1'b1;
                end
            end
            if (take0) begin
                if (mode == MD_TRUNC) begin
                    next_res_high = 8'h00;
                    next_res_low = conv_data_i[9:2];
                end else if (lock == LK_HELD) begin
                    next_int_st[`AR_EV_LOST] = 1'b1;
                end else begin
                    case (mode)
                        MD_RIGHT: begin
                            next_res_high = {6'h00, conv_data_i[9:8]};
                            next_res_low = conv_data_i[7:0];
                        end
                        MD_LEFT: begin
                            next_res_high = conv_data_i[9:2];
                            next_res_low = {conv_data_i[1:0], 6'h00};
                        end
                        default: begin
                            next_res_high = {~conv_data_i[9],
                                conv_data_i[8:2]};
                            next_res_low = {conv_data_i[1:0], 6'h00};
                        end
                    endcase
                end
            end
        end
        next_chan_out = next_scan_en ? {3'b000, next_scan_idx} : next_chan_sel;
        for (int p = 0; p < NPIN; p++) begin
            next_sel[p] = next_chan_out == 5'(p);
        end
        next_irq = |(next_int_st & next_int_msk);
        next_rd_data = 8'h00;
        if (rd_en_i) begin
            case (addr_i)
                `AR_OFS_STAT: next_rd_data = {done_flag & ~ien, ien,
                    continuous_o, chan_sel};
                `AR_OFS_CLK: next_rd_data = {clk_cfg, 2'b00};
                `AR_OFS_HIGH: next_rd_data = res_high;
                `AR_OFS_LOW0: next_rd_data = res_low;
                `AR_OFS_LOW1: next_rd_data = scan_res[1];
                `AR_OFS_LOW2: next_rd_data = scan_res[2];
                `AR_OFS_LOW3: next_rd_data = scan_res[3];
                `AR_OFS_SCAN: next_rd_data = {5'h00, scan_cnt, scan_en};
                `AR_OFS_IST: next_rd_data = {6'h00, int_st};
                `AR_OFS_IMSK: next_rd_data = {6'h00, int_msk};
                default: next_rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            res_high <= `AR_RST_RES;
            res_low <= `AR_RST_RES;
            done_flag <= 1'b0;
            ien <= 1'b0;
            continuous_o <= 1'b0;
            chan_sel <= `AR_RST_CHAN;
            clk_cfg <= `AR_RST_CFG;
            scan_cnt <= 2'b00;
            scan_en <= 1'b0;
            scan_idx <= 2'b00;
            lock <= LK_OPEN;
            int_st <= 2'b00;
            int_msk <= 2'b00;
            conv_req_o <= 1'b0;
            conv_start_o <= 1'b0;
            conv_channel_o <= `AR_RST_CHAN;
            analog_sel_o <= '0;
            irq_o <= 1'b0;
            rd_data_o <= 8'h00;
        end else begin
            res_high <= next_res_high;
            res_low <= next_res_low;
            done_flag <= next_done_flag;
            ien <= next_ien;
            continuous_o <= next_cont;
            chan_sel <= next_chan_sel;
            clk_cfg <= next_clk_cfg;
            scan_cnt <= next_scan_cnt;
            scan_en <= next_scan_en;
            scan_idx <= next_scan_idx;
            lock <= next_lock;
            int_st <= next_int_st;
            int_msk <= next_int_msk;
            conv_req_o <= next_req;
            conv_start_o <= next_start;
            conv_channel_o <= next_chan_out;
            analog_sel_o <= next_sel;
            irq_o <= next_irq;
            rd_data_o <= next_rd_data;
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_trunc_place: assert property (
        conv_done_i && take0 && mode == MD_TRUNC
        |=> res_high == 8'h00 && res_low == $past(conv_data_i[9:2]))
        else $error("truncated placement wrong");
    a_right_place: assert property (
        conv_done_i && take0 && mode == MD_RIGHT && lock == LK_OPEN
        |=> res_high == {6'h00, $past(conv_data_i[9:8])}
        && res_low == $past(conv_data_i[7:0]))
        else $error("right justified placement wrong");
    a_left_place: assert property (
        conv_done_i && take0 && mode == MD_LEFT && lock == LK_OPEN
        |=> res_high == $past(conv_data_i[9:2])
        && res_low == {$past(conv_data_i[1:0]), 6'h00})
        else $error("left justified placement wrong");
    a_signed_place: assert property (
        conv_done_i && take0 && mode == MD_SIGNED && lock == LK_OPEN
        |=> res_high[7] != $past(conv_data_i[9])
        && res_high[6:0] == $past(conv_data_i[8:2]))
        else $error("signed top bit not inverted");
    a_lock_hold: assert property (
        rd_high0 && mode != MD_TRUNC && !wr_clk ##1 (!rd_low0 && !wr_clk) [*3]
        |-> $stable(res_low) && $stable(res_high))
        else $error("result changed while frozen");
    a_lost_flag: assert property (
        conv_done_i && take0 && lock == LK_HELD && mode != MD_TRUNC
        |=> int_st[`AR_EV_LOST] && (irq_o || !int_msk[`AR_EV_LOST]))
        else $error("dropped result not flagged");
    a_scan_order: assert property (
        conv_done_i && scan_en && !wr_scan && !wr_stat
        && scan_idx != scan_cnt
        |=> scan_idx == $past(scan_idx) + 2'b01 && conv_start_o)
        else $error("scan did not advance");
    a_scan_keep: assert property (
        conv_done_i && scan_en && scan_idx == 2'b10
        |=> scan_res[2] == $past(conv_data_i[9:2]))
        else $error("scan result not stored");
    a_done_clear: assert property (
        rd_low_any && !ien && !conv_done_i |=> !done_flag)
        else $error("done flag survived low read");
    a_req_drop: assert property (
        (wr_stat || rd_low0 || rd_high0) && !conv_done_i |=> !conv_req_o)
        else $error("request not withdrawn");
    a_pin_take: assert property (
        conv_channel_o == 5'h02 |-> analog_sel_o == NPIN'(4))
        else $error("wrong analog pin taken");
    a_ro_result: assert property (
        wr_en_i && addr_i == `AR_OFS_HIGH && !conv_done_i
        |=> $stable(res_high))
        else $error("result register took a write");
    a_scan_read: assert property (
        rd_en_i && addr_i == `AR_OFS_SCAN
        |=> rd_data_o == {5'h00, $past(scan_cnt), $past(scan_en)})
        else $error("scan control read wrong");
    c_frozen_drop: cover property (conv_done_i && lock == LK_HELD);
    c_scan_wrap: cover property (
        conv_done_i && scan_en && scan_cnt == 2'b11 && scan_idx == 2'b11);
    c_pair_read: cover property (rd_high0 ##[1:5] rd_low0);
endmodule
